// ---- jrb_map.svh ----
`ifndef JRB_MAP_SVH
`define JRB_MAP_SVH
// Clock rates and the derived link clock divider
`define JRB_MCLK_PERIOD_NS 8
`define JRB_TCK_PERIOD_NS  64
`define JRB_TCK_HALF       (`JRB_TCK_PERIOD_NS / (2 * `JRB_MCLK_PERIOD_NS))
`define JRB_PH_W           3
// Counter widths
`define JRB_CNT_W          24
`define JRB_PK_W           9
`define JRB_ERR_W          16
// Clock counts of each walk through the test access port
`define JRB_N_TLR          5
`define JRB_N_ONE          1
`define JRB_N_SEL_DR       2
`define JRB_N_SEL_IR_SHORT 2
`define JRB_N_SEL_IR       3
`define JRB_N_ENTER_SHIFT  2
`define JRB_N_IR_BODY      5
// Last instruction bit plus the pass through the update state
`define JRB_N_IR_EXIT      2
`define JRB_N_SHUT_IDLE    24
`define JRB_N_PKT_BODY     271
`define JRB_N_TLR_END      3
`define JRB_LAST_STEP      5'h19
// Instruction codes, six bits, shifted low bit first
`define JRB_IR_SHUTDOWN    6'h0d
`define JRB_IR_CFG_IN      6'h05
`define JRB_IR_CFG_OUT     6'h04
// Setup packet words, high bit first
`define JRB_W_DUMMY        16'hffff
`define JRB_W_SYNC_HI      16'haa99
`define JRB_W_SYNC_LO      16'h5566
`define JRB_W_CMD_HDR      16'h30a1
`define JRB_W_CMD_VAL_A    16'h0008
`define JRB_W_CMD_VAL_RB   16'h0004
`define JRB_W_HDR_B        16'h31a1
`define JRB_W_DONTCARE     16'h0000
`define JRB_W_FAR_HDR      16'h3022
`define JRB_W_ZERO         16'h0000
`define JRB_W_RD_HDR       16'h4880
`define JRB_W_NOOP         16'h2000
`endif

// ---- jrb_pkg.sv ----
`default_nettype none
package jrb_pkg;
   // Where the data bit of a step comes from
   typedef enum logic [1:0] {
      JRB_SRC_X   = 2'h0,
      JRB_SRC_IR  = 2'h1,
      JRB_SRC_PKT = 2'h2,
      JRB_SRC_RB  = 2'h3
   } jrb_src_e;
   // Sequencer states, Gray along idle, issue, wait, finish
   typedef enum logic [1:0] {
      JRB_IDLE  = 2'h0,
      JRB_ISSUE = 2'h1,
      JRB_WAIT  = 2'h3,
      JRB_FIN   = 2'h2
   } jrb_st_e;
   // One step of the pin walk
   typedef struct packed {
      logic             tms;
      jrb_src_e         src;
      logic [23:0]      count;
   } jrb_step_s;
   // Link driver state
   typedef struct packed {
      logic             busy;
      logic [2:0]       ph;
      logic             tck;
      logic             tms;
      logic             tdi;
      logic             done;
      logic             tdo_bit;
      logic             s1;
      logic             s2;
   } jrb_drv_s;
   // Sequencer state
   typedef struct packed {
      jrb_st_e          st;
      logic [4:0]       step;
      logic [23:0]      cnt;
      logic [8:0]       pk;
      logic [23:0]      rbi;
      logic             valid;
      logic             tms;
      logic             tdi;
      logic             rd_bit;
      logic             rd_valid;
      logic             rd_keep;
      logic [15:0]      err;
      logic             fail;
      logic             busy;
      logic             done;
   } jrb_seq_s;
endpackage
`default_nettype wire

// ---- jrb_bit_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// One TCK bit: request with TMS and TDI, answer with sampled TDO
interface jrb_bit_if;
   logic valid;   // Bit request
   logic ready;   // Driver idle
   logic tms;     // Mode level for this bit
   logic tdi;     // Data level for this bit
   logic done;    // One-cycle end of bit
   logic tdo;     // TDO sampled before the rising edge
   modport seq (output valid, tms, tdi, input ready, done, tdo);
   modport drv (input valid, tms, tdi, output ready, done, tdo);
endinterface
`default_nettype wire

// ---- jrb_tck_drv.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "jrb_map.svh"
// Makes TCK from mclk and plays one bit per request
module jrb_tck_drv (
   input  wire logic mclk,
   input  wire logic reset,
   jrb_bit_if.drv    bi,
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   jrb_pkg::jrb_drv_s r_reg;   // Registered state
   jrb_pkg::jrb_drv_s r_next;  // Next state

   // Low phase first, so TMS and TDI change while TCK is low
   always_comb begin
      r_next = r_reg;
      r_next.done = 1'b0;
      r_next.s1 = tdo;
      r_next.s2 = r_reg.s1;
      if (!r_reg.busy) begin
         // Accept a bit only while idle
         if (bi.valid) begin
            r_next.busy = 1'b1;
            r_next.ph = '0;
            r_next.tms = bi.tms;
            r_next.tdi = bi.tdi;
         end
      end else begin
         r_next.ph = r_reg.ph + 3'h1;
         // Sample TDO just before the rising edge; sync delay is 2 of 4 cycles
         if (r_reg.ph == `JRB_PH_W'(`JRB_TCK_HALF - 1)) begin
            r_next.tdo_bit = r_reg.s2;
            r_next.tck = 1'b1;
         end
         if (r_reg.ph == `JRB_PH_W'(2 * `JRB_TCK_HALF - 1)) begin
            r_next.tck = 1'b0;
            r_next.busy = 1'b0;
            r_next.done = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign bi.ready = !r_reg.busy;
   assign bi.done = r_reg.done;
   assign bi.tdo = r_reg.tdo_bit;
   assign tck = r_reg.tck;
   assign tms = r_reg.tms;
   assign tdi = r_reg.tdi;

   // A taken bit ends exactly one TCK period later
   a_bit_length: assert property (@(posedge mclk) disable iff (reset)
      (bi.valid && !r_reg.busy) |-> !bi.done [*8] ##1 !bi.done ##1 bi.done)
      else $error("bit did not end after one TCK period");
   // High phase lasts half a period
   a_tck_high: assert property (@(posedge mclk) disable iff (reset)
      $rose(tck) |-> tck [*4] ##1 !tck)
      else $error("TCK high phase wrong");
   // Pins never move while TCK is high
   a_pins_stable: assert property (@(posedge mclk) disable iff (reset)
      (tck && $past(tck)) |-> ($stable(tms) && $stable(tdi)))
      else $error("TMS or TDI moved while TCK high");
endmodule // jrb_tck_drv
`default_nettype wire

// ---- jrb_host.sv ----
// Operation
// - Config-in instruction 00101, last bit TMS high
// - TMS high two, low two into shift
// - Dummy word then both sync words first
// - Command header with 0008, later 0004 readback
// - Header 31A1 plus filler; address header, zeros
// - Read header pair, then two no-op words
// - 271 clocks TMS low, last bit high
// - TMS high three, low two into IR
// - Config-out instruction 00100, last bit TMS high
// - Readback bits minus one low, last high
// - Three TMS high clocks end in Select-DR-Scan
// - Compare unmasked bits, ignore masked bits
// - Mask and expected aligned from pad frame
// - Host switches itself from write to read
// - First returned frame is dummy, discard; here only flagged on rd_keep
// - Shutdown instruction, then 24 idle clocks
`timescale 1ns/1ps
`default_nettype none
`include "jrb_map.svh"
module jrb_host #(
   parameter int unsigned RB_BITS    = 2080,  // Total readback bits, pad frame included
   parameter int unsigned FRAME_BITS = 1040   // Bits in one frame
) (
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic        start,      // Begin one readback session
   input  wire logic        exp_bit,    // Expected bit for rb_index
   input  wire logic        mask_bit,   // Mask bit for rb_index, 1 ignores
   output logic [23:0]      rb_index,   // Index of the readback bit in flight
   output logic             rd_bit,     // Returned bit
   output logic             rd_valid,   // One-cycle strobe for rd_bit
   output logic             rd_keep,    // Bit lies past the dummy frame
   output logic [15:0]      err_count,  // Unmasked mismatches
   output logic             fail,       // Any unmasked mismatch
   output logic             busy,       // Session in progress
   output logic             done,       // One-cycle end of session
   output logic             tck,        // Link clock, divided from mclk
   output logic             tms,        // Mode select pin
   output logic             tdi,        // Data to the device
   input  wire logic        tdo         // Data from the device
);
   jrb_pkg::jrb_seq_s r_reg;    // Registered state
   jrb_pkg::jrb_seq_s r_next;   // Next state
   jrb_pkg::jrb_step_s cur;     // Step now being played
   logic               cur_tdi; // Data level of the bit now being issued
   // Selects are taken from locals, not straight off a function call
   logic [5:0]         cur_ir;   // Instruction code of the current step
   logic [15:0]        cur_word; // Packet word holding the current bit

   jrb_bit_if bi ();            // Bit requests to the link driver

   // Pin walk, one entry per stretch of equal TMS
   function automatic jrb_pkg::jrb_step_s step_of(input logic [4:0] s);
      jrb_pkg::jrb_step_s t;
      t.tms = 1'b0;
      t.src = jrb_pkg::JRB_SRC_X;
      t.count = `JRB_CNT_W'(`JRB_N_ONE);
      case (s)
         // Reach test-logic-reset, then idle
         5'h00: t = '{1'b1, jrb_pkg::JRB_SRC_X, `JRB_CNT_W'(`JRB_N_TLR)};
         5'h01: t = '{1'b0, jrb_pkg::JRB_SRC_X, `JRB_CNT_W'(`JRB_N_ONE)};
         5'h02: t = '{1'b1, jrb_pkg::JRB_SRC_X, `JRB_CNT_W'(`JRB_N_SEL_IR_SHORT)};
         5'h03: t = '{1'b0, jrb_pkg::JRB_SRC_X, `JRB_CNT_W'(`JRB_N_ENTER_SHIFT)};
         // Shutdown instruction and its idle wait
         5'h04: t = '{1'b0, jrb_pkg::JRB_SRC_IR, `JRB_CNT_W'(`JRB_N_IR_BODY)};
         // Last bit, then through Update-IR so the wait is spent in idle
         5'h05: t = '{1'b1, jrb_pkg::JRB_SRC_X, `JRB_CNT_W'(`JRB_N_IR_EXIT)};
         5'h06: t = '{1'b0, jrb_pkg::JRB_SRC_X, `JRB_CNT_W'(`JRB_N_SHUT_IDLE)};
         5'h07: t = '{1'b1, jrb_pkg::JRB_SRC_X, `JRB_CNT_W'(`JRB_N_SEL_IR_SHORT)};
         5'h08: t = '{1'b0, jrb_pkg::JRB_SRC_X, `JRB_CNT_W'(`JRB_N_ENTER_SHIFT)};
         // Config-in instruction, body then last bit with TMS high
         5'h09: t = '{1'b0, jrb_pkg::JRB_SRC_IR, `JRB_CNT_W'(`JRB_N_IR_BODY)};
         5'h0a: t = '{1'b1, jrb_pkg::JRB_SRC_X, `JRB_CNT_W'(`JRB_N_ONE)};
         // Select-DR then Shift-DR
         5'h0b: t = '{1'b1, jrb_pkg::JRB_SRC_X, `JRB_CNT_W'(`JRB_N_SEL_DR)};
         5'h0c: t = '{1'b0, jrb_pkg::JRB_SRC_X, `JRB_CNT_W'(`JRB_N_ENTER_SHIFT)};
         // Setup packets, last bit leaves Shift-DR
         5'h0d: t = '{1'b0, jrb_pkg::JRB_SRC_PKT, `JRB_CNT_W'(`JRB_N_PKT_BODY)};
         5'h0e: t = '{1'b1, jrb_pkg::JRB_SRC_PKT, `JRB_CNT_W'(`JRB_N_ONE)};
         // Back to Shift-IR
         5'h0f: t = '{1'b1, jrb_pkg::JRB_SRC_X, `JRB_CNT_W'(`JRB_N_SEL_IR)};
         5'h10: t = '{1'b0, jrb_pkg::JRB_SRC_X, `JRB_CNT_W'(`JRB_N_ENTER_SHIFT)};
         // Config-out instruction turns the link round to reading
         5'h11: t = '{1'b0, jrb_pkg::JRB_SRC_IR, `JRB_CNT_W'(`JRB_N_IR_BODY)};
         5'h12: t = '{1'b1, jrb_pkg::JRB_SRC_X, `JRB_CNT_W'(`JRB_N_ONE)};
         5'h13: t = '{1'b1, jrb_pkg::JRB_SRC_X, `JRB_CNT_W'(`JRB_N_SEL_DR)};
         5'h14: t = '{1'b0, jrb_pkg::JRB_SRC_X, `JRB_CNT_W'(`JRB_N_ENTER_SHIFT)};
         // Readback: all bits but one low, last bit high
         5'h15: t = '{1'b0, jrb_pkg::JRB_SRC_RB, `JRB_CNT_W'(RB_BITS - 1)};
         5'h16: t = '{1'b1, jrb_pkg::JRB_SRC_RB, `JRB_CNT_W'(`JRB_N_ONE)};
         5'h17: t = '{1'b1, jrb_pkg::JRB_SRC_X, `JRB_CNT_W'(`JRB_N_SEL_IR)};
         5'h18: t = '{1'b0, jrb_pkg::JRB_SRC_X, `JRB_CNT_W'(`JRB_N_ENTER_SHIFT)};
         // Three high clocks from Shift-IR end in Select-DR-Scan
         5'h19: t = '{1'b1, jrb_pkg::JRB_SRC_X, `JRB_CNT_W'(`JRB_N_TLR_END)};
         default: t = '{1'b1, jrb_pkg::JRB_SRC_X, `JRB_CNT_W'(`JRB_N_ONE)};
      endcase
      return t;
   endfunction

   // Instruction for the step; one code per shift-IR stretch
   function automatic logic [5:0] ir_of(input logic [4:0] s);
      if (s < 5'h09) begin
         return `JRB_IR_SHUTDOWN;
      end else if (s < 5'h11) begin
         return `JRB_IR_CFG_IN;
      end else begin
         return `JRB_IR_CFG_OUT;
      end
   endfunction

   // Setup stream; a spare leading dummy pads it to 272 bits
   function automatic logic [15:0] word_of(input logic [4:0] w);
      case (w)
         5'h00: return `JRB_W_DUMMY;
         5'h01: return `JRB_W_DUMMY;
         5'h02: return `JRB_W_SYNC_HI;
         5'h03: return `JRB_W_SYNC_LO;
         5'h04: return `JRB_W_CMD_HDR;
         5'h05: return `JRB_W_CMD_VAL_A;
         5'h06: return `JRB_W_HDR_B;
         5'h07: return `JRB_W_DONTCARE;
         5'h08: return `JRB_W_FAR_HDR;
         5'h09: return `JRB_W_ZERO;
         5'h0a: return `JRB_W_ZERO;
         5'h0b: return `JRB_W_CMD_HDR;
         5'h0c: return `JRB_W_CMD_VAL_RB;
         5'h0d: return `JRB_W_RD_HDR;
         5'h0e: return `JRB_W_ZERO;
         5'h0f: return `JRB_W_NOOP;
         5'h10: return `JRB_W_NOOP;
         default: return `JRB_W_ZERO;
      endcase
   endfunction

   // Data level of the current bit
   always_comb begin
      cur = step_of(r_reg.step);
      cur_ir = ir_of(r_reg.step);
      cur_word = word_of(r_reg.pk[8:4]);
      case (cur.src)
         // Instruction bits low bit first
         jrb_pkg::JRB_SRC_IR: cur_tdi = cur_ir[r_reg.cnt[2:0]];
         // Packet bits high bit first
         jrb_pkg::JRB_SRC_PKT: cur_tdi = cur_word[~r_reg.pk[3:0]];
         // Readback holds TDI low; also the last instruction bit
         default: cur_tdi = 1'b0;
      endcase
   end

   // Sequencer: issue one bit, wait for its end, advance
   always_comb begin
      r_next = r_reg;
      r_next.rd_valid = 1'b0;
      r_next.done = 1'b0;
      case (r_reg.st)
         // Idle until start; clears the verdict of the last session
         jrb_pkg::JRB_IDLE: begin
            if (start) begin
               r_next.st = jrb_pkg::JRB_ISSUE;
               r_next.step = '0;
               r_next.cnt = '0;
               r_next.pk = '0;
               r_next.rbi = '0;
               r_next.err = '0;
               r_next.fail = 1'b0;
               r_next.busy = 1'b1;
            end
         end
         // Present the bit; the driver takes it while ready
         jrb_pkg::JRB_ISSUE: begin
            r_next.valid = 1'b1;
            r_next.tms = cur.tms;
            r_next.tdi = cur_tdi;
            if (r_reg.valid && bi.ready) begin
               r_next.valid = 1'b0;
               r_next.st = jrb_pkg::JRB_WAIT;
            end
         end
         // Bit finished: collect TDO, move the counters
         jrb_pkg::JRB_WAIT: begin
            if (bi.done) begin
               r_next.st = jrb_pkg::JRB_ISSUE;
               if (cur.src == jrb_pkg::JRB_SRC_PKT) begin
                  r_next.pk = r_reg.pk + 9'h001;
               end
               if (cur.src == jrb_pkg::JRB_SRC_RB) begin
                  r_next.rd_valid = 1'b1;
                  r_next.rd_bit = bi.tdo;
                  // Pad frame still flows, only flagged
                  r_next.rd_keep = (r_reg.rbi >= `JRB_CNT_W'(FRAME_BITS));
                  r_next.rbi = r_reg.rbi + 24'h000001;
                  // Mask 1 ignores the bit
                  if (!mask_bit && (bi.tdo != exp_bit)) begin
                     r_next.err = r_reg.err + 16'h0001;
                     r_next.fail = 1'b1;
                  end
               end
               if (r_reg.cnt == cur.count - 24'h000001) begin
                  r_next.cnt = '0;
                  if (r_reg.step == `JRB_LAST_STEP) begin
                     r_next.st = jrb_pkg::JRB_FIN;
                  end else begin
                     r_next.step = r_reg.step + 5'h01;
                  end
               end else begin
                  r_next.cnt = r_reg.cnt + 24'h000001;
               end
            end
         end
         // Session over; one pulse on done
         jrb_pkg::JRB_FIN: begin
            r_next.st = jrb_pkg::JRB_IDLE;
            r_next.busy = 1'b0;
            r_next.done = 1'b1;
         end
         default: begin
            r_next = '0;
         end
      endcase
   end

   // State register
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // Requests to the link driver
   assign bi.valid = r_reg.valid;
   assign bi.tms = r_reg.tms;
   assign bi.tdi = r_reg.tdi;

   // Link driver makes TCK by division, so no second domain here
   jrb_tck_drv u_drv (
      .mclk  (mclk),
      .reset (reset),
      .bi    (bi),
      .tck   (tck),
      .tms   (tms),
      .tdi   (tdi),
      .tdo   (tdo)
   );

   // User-side outputs, all registered
   assign rb_index = r_reg.rbi;
   assign rd_bit = r_reg.rd_bit;
   assign rd_valid = r_reg.rd_valid;
   assign rd_keep = r_reg.rd_keep;
   assign err_count = r_reg.err;
   assign fail = r_reg.fail;
   assign busy = r_reg.busy;
   assign done = r_reg.done;

   // Readback bits never drive TDI high
   a_tdi_quiet_rb: assert property (@(posedge mclk) disable iff (reset)
      (r_reg.valid && cur.src == jrb_pkg::JRB_SRC_RB) |-> !r_reg.tdi)
      else $error("TDI not constant during readback");
   // Last config-in and config-out instruction bit goes out with TMS high and TDI low
   a_ir_last_bit: assert property (@(posedge mclk) disable iff (reset)
      (r_reg.valid && (r_reg.step == 5'h0a || r_reg.step == 5'h12)) |-> (r_reg.tms && !r_reg.tdi))
      else $error("instruction last bit wrong");
   // First sync word follows the dummy words
   a_sync_first: assert property (@(posedge mclk) disable iff (reset)
      (r_reg.valid && r_reg.step == 5'h0d && r_reg.pk == 9'h020) |-> r_reg.tdi)
      else $error("sync word high bit wrong");
   // Dummy frame bits are never kept
   a_pad_dropped: assert property (@(posedge mclk) disable iff (reset)
      (rd_valid && rb_index <= `JRB_CNT_W'(FRAME_BITS)) |-> !rd_keep)
      else $error("pad frame bit kept");
   // Unmasked mismatch raises fail next cycle
   a_mismatch_flag: assert property (@(posedge mclk) disable iff (reset)
      (r_reg.st == jrb_pkg::JRB_WAIT && bi.done && cur.src == jrb_pkg::JRB_SRC_RB
       && !mask_bit && bi.tdo != exp_bit) |=> (fail && err_count == $past(err_count) + 16'h0001))
      else $error("mismatch not counted");
   // Masked bits leave the count alone
   a_masked_ignored: assert property (@(posedge mclk) disable iff (reset)
      (r_reg.st == jrb_pkg::JRB_WAIT && bi.done && mask_bit) |=> $stable(err_count))
      else $error("masked bit counted");
   // Start leads to busy within two cycles
   a_start_busy: assert property (@(posedge mclk) disable iff (reset)
      (r_reg.st == jrb_pkg::JRB_IDLE && start) |=> busy ##1 r_reg.valid)
      else $error("start not taken");
   // Packet body keeps TMS low, the last packet bit raises it
   a_pkt_tms: assert property (@(posedge mclk) disable iff (reset)
      (r_reg.valid && cur.src == jrb_pkg::JRB_SRC_PKT) |-> (r_reg.tms == (r_reg.step == 5'h0e)))
      else $error("packet TMS level wrong");
   // Readback keeps TMS low until its last bit
   a_rb_tms: assert property (@(posedge mclk) disable iff (reset)
      (r_reg.valid && cur.src == jrb_pkg::JRB_SRC_RB) |-> (r_reg.tms == (r_reg.step == 5'h16)))
      else $error("readback TMS level wrong");
   // The closing walk holds TMS high
   a_end_tms: assert property (@(posedge mclk) disable iff (reset)
      (r_reg.valid && r_reg.step == `JRB_LAST_STEP) |-> r_reg.tms)
      else $error("closing TMS level wrong");
endmodule // jrb_host
`default_nettype wire

// ---- jrb_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "jrb_map.svh"
// Behavioural device behind the test access port, clocked only by the host's tck
module jrb_dev_model (
   input  wire logic        reset,
   input  wire logic        tck,
   input  wire logic        tms,
   input  wire logic        tdi,
   output logic             tdo,
   output logic [5:0]       ir_log [0:2],
   output logic [15:0]      words [0:16],
   output logic [8:0]       n_bits,
   output logic [7:0]       idle_cnt,
   output logic [23:0]      rb_n,
   output logic             tdi_seen
);
   // Next state for TMS high and TMS low, indexed by the current state
   localparam logic [3:0] GO1 [16] = '{4'h0, 4'h2, 4'h9, 4'h5, 4'h5, 4'h8, 4'h7, 4'h8,
                                       4'h2, 4'h0, 4'hc, 4'hc, 4'hf, 4'he, 4'hf, 4'h2};
   localparam logic [3:0] GO0 [16] = '{4'h1, 4'h1, 4'h3, 4'h4, 4'h4, 4'h6, 4'h6, 4'h4,
                                       4'h1, 4'ha, 4'hb, 4'hb, 4'hd, 4'hd, 4'hb, 4'h1};
   logic [3:0]  st;     // Controller state
   logic [5:0]  ir;     // Instruction shifter
   logic [5:0]  cur;    // Instruction in force
   logic [15:0] sh;     // Packet shifter
   logic [1:0]  n_ir;   // Instructions seen this session
   logic        rb_ok;  // Setup stream was accepted
   // Readback is only armed once sync and the read request arrived
   assign rb_ok = words[2] == 16'haa99 && words[3] == 16'h5566 &&
                  words[12] == 16'h0004 && words[13] == 16'h4880;
   // Rising edge: walk the controller and capture what the host shifts in
   always_ff @(posedge tck or posedge reset) begin
      if (reset) begin
         st <= 4'h0;
         cur <= 6'h3f;
      end else begin
         st <= tms ? GO1[st] : GO0[st];
         if (st == 4'h0) begin
            // Logs restart with each session
            n_ir <= 2'h0;
            n_bits <= 9'h000;
            idle_cnt <= 8'h00;
            rb_n <= 24'h000000;
            tdi_seen <= 1'b0;
            cur <= 6'h3f;
         end
         if (st == 4'hb) begin
            ir <= {tdi, ir[5:1]};
         end
         if (st == 4'hf) begin
            cur <= ir;
            ir_log[n_ir] <= ir;
            n_ir <= n_ir + 2'h1;
         end
         if (st == 4'h4 && cur == `JRB_IR_CFG_IN) begin
            sh <= {sh[14:0], tdi};
            n_bits <= n_bits + 9'h001;
            if (n_bits[3:0] == 4'hf) begin
               words[n_bits[8:4]] <= {sh[14:0], tdi};
            end
         end
         if (st == 4'h4 && cur == `JRB_IR_CFG_OUT) begin
            rb_n <= rb_n + 24'h000001;
            tdi_seen <= tdi_seen | tdi;
         end
         if (st == 4'h1 && cur == `JRB_IR_SHUTDOWN) begin
            idle_cnt <= idle_cnt + 8'h01;
         end
      end
   end
   // Falling edge: present the next frame bit, or garbage when not shifting out
   always_ff @(negedge tck or posedge reset) begin
      if (reset) begin
         tdo <= 1'b0;
      end else if (st == 4'h4 && cur == `JRB_IR_CFG_OUT) begin
         tdo <= (rb_n[0] ^ rb_n[2] ^ rb_n[4]) ^ ~rb_ok;
      end else begin
         // Released line: no stale value for the host to trust
         tdo <= ~tdo;
      end
   end
endmodule // jrb_dev_model
`default_nettype wire

// ---- jrb_host_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module jrb_host_test;
   localparam int unsigned RB  = 40;  // Short readback keeps the run brief
   localparam int unsigned FRM = 16;  // Short frame; the first one is pad
   logic        mclk, reset, start, exp_bit, mask_bit, tdo, tdi_seen;
   logic        rd_bit, rd_valid, rd_keep, fail, busy, done, tck, tms, tdi;
   logic [23:0] rb_index, rb_n;
   logic [15:0] err_count;
   logic [5:0]  ir_log [0:2];
   logic [15:0] words [0:16];
   logic [8:0]  n_bits;
   logic [7:0]  idle_cnt;
   logic [1:0]  mode;  // 1 flips some expected bits and masks others
   int          n_mismatch, n_checks, n_rd, n_done;
   // Setup stream the device must receive
   logic [15:0] pkt [0:16] = '{16'hffff, 16'hffff, 16'haa99, 16'h5566, 16'h30a1, 16'h0008,
      16'h31a1, 16'h0000, 16'h3022, 16'h0000, 16'h0000, 16'h30a1, 16'h0004, 16'h4880,
      16'h0000, 16'h2000, 16'h2000};
   always #4 mclk = ~mclk;
   jrb_host #(.RB_BITS(RB), .FRAME_BITS(FRM)) jrb_host_i (.mclk(mclk), .reset(reset),
      .start(start), .exp_bit(exp_bit), .mask_bit(mask_bit), .rb_index(rb_index),
      .rd_bit(rd_bit), .rd_valid(rd_valid), .rd_keep(rd_keep), .err_count(err_count),
      .fail(fail), .busy(busy), .done(done), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
   jrb_dev_model jrb_dev_model_i (.reset(reset), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo), .ir_log(ir_log), .words(words), .n_bits(n_bits), .idle_cnt(idle_cnt),
      .rb_n(rb_n), .tdi_seen(tdi_seen));
   // Frame data the model returns, and the flip and mask patterns
   function automatic logic pat(input logic [23:0] i);
      return i[0] ^ i[2] ^ i[4];
   endfunction
   function automatic logic flip(input logic [23:0] i);
      return mode[0] && (i % 3 == 0);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Expected and mask bits follow the bit in flight
   always @(posedge mclk) begin
      exp_bit <= pat(rb_index) ^ flip(rb_index);
      mask_bit <= mode[0] && (rb_index % 5 == 0);
   end
   // Every returned bit is judged mid-cycle, where the outputs have settled
   always @(negedge mclk) begin
      if (rd_valid === 1'b1) begin
         chk(rd_bit, pat(n_rd));
         chk(rd_keep, n_rd >= FRM);
         n_rd++;
      end
      if (done === 1'b1) begin
         n_done++;
      end
   end
   // One session; again pokes start mid-run, which must be ignored
   task automatic run_session(input logic [1:0] m, input bit again);
      int t;
      @(posedge mclk);
      mode <= m;
      n_rd = 0;
      n_done = 0;
      start <= 1'b1;
      @(posedge mclk);
      start <= 1'b0;
      if (again) begin
         repeat (50) @(posedge mclk);
         start <= 1'b1;
         @(posedge mclk);
         start <= 1'b0;
      end
      t = 0;
      while (done !== 1'b1 && t < 20000) begin
         @(negedge mclk);
         t++;
      end
      chk(t < 20000, 1);
      repeat (30) @(posedge mclk);
      @(negedge mclk);
      chk(busy, 0);
      chk(n_done, 1);
      chk(n_rd, RB);
      chk(rb_index, RB);
   endtask
   task automatic t_reset();
      @(negedge mclk);
      chk({busy, done, tck, tms, tdi, rd_valid, fail}, 0);
      chk(err_count, 0);
   endtask
   // Matching data: full walk, stream contents and a clean verdict
   task automatic t_clean();
      run_session(2'h0, 1'b0);
      chk(err_count, 0);
      chk(fail, 0);
      chk(ir_log[0], 6'h0d);
      chk(ir_log[1], 6'h05);
      chk(ir_log[2], 6'h04);
      chk(idle_cnt, 24);
      chk(n_bits, 272);
      for (int i = 0; i < 17; i++) chk(words[i], pkt[i]);
      chk(rb_n, RB);
      chk(tdi_seen, 0);
   endtask
   // Flipped and masked bits: only unmasked flips count as errors
   task automatic t_masked();
      int e;
      e = 0;
      for (int i = 0; i < RB; i++) begin
         if (i % 3 == 0 && i % 5 != 0) begin
            e++;
         end
      end
      run_session(2'h1, 1'b1);
      chk(err_count, e);
      chk(fail, 1);
   endtask
   initial begin
      mclk = 1'b0;
      reset = 1'b1;
      start = 1'b0;
      exp_bit = 1'b0;
      mask_bit = 1'b0;
      mode = 2'h0;
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      t_reset();
      t_clean();
      t_masked();
      t_clean();
      end_of_test();
   end
   // Three sessions take about 13000 cycles; cut a hang well beyond that
   initial begin
      repeat (40000) @(posedge mclk);
      n_mismatch++;
      end_of_test();
   end
endmodule // jrb_host_test
`default_nettype wire
